// >>> hdl/hiu_pkg.sv
// constants for the interrupt microframe descriptor block
package hiu_pkg;
	// ====================================================================
	// register indices on the plain register port
	localparam logic [3:0] ADDR_DW1_LO    = 4'h0;
	localparam logic [3:0] ADDR_DW3_HI    = 4'h1;
	localparam logic [3:0] ADDR_DW4_LO    = 4'h2;
	localparam logic [3:0] ADDR_DW5_HI    = 4'h3;
	localparam logic [3:0] ADDR_DW6_LO    = 4'h4;
	localparam logic [3:0] ADDR_DW7_HI    = 4'h5;
	localparam logic [3:0] ADDR_CTRL      = 4'h6;
	localparam logic [3:0] ADDR_IRQ_STAT  = 4'h7;
	localparam logic [3:0] ADDR_IRQ_MASK  = 4'h8;

	// ====================================================================
	// field positions
	localparam int FRAME_SEL_LSB   = 3;    // descriptor_frame_select in dw1 lo [7:3]
	localparam int ACTIVE_BIT      = 31;   // bit 63 of dw3 seen through the high word
	localparam int CTRL_VALID_BIT  = 0;
	localparam int CTRL_OUT_BIT    = 1;
	localparam int RES_TXERR_BIT   = 0;
	localparam int RES_BABBLE_BIT  = 1;
	localparam int RES_UNDERRUN_BIT = 2;
	localparam int EV_DONE_BIT     = 0;
	localparam int EV_ERR_BIT      = 1;

	// ====================================================================
	// widths and reset values
	localparam int NUM_UFRAMES     = 8;
	localparam int COUNT_W         = 12;
	localparam int RESULT_W        = 3;
	localparam int FRAME_W         = 5;
	localparam int EVENT_W         = 2;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;
	localparam logic [11:0] RST_COUNT  = 12'h000;
	localparam logic [2:0]  RST_RESULT = 3'h0;

	typedef enum logic {
		ST_IDLE,
		ST_BUSY
	} hiu_state_e;
endpackage

// >>> hdl/hiu_uframe_desc.sv
// high-speed interrupt microframe descriptor: schedule, write-back, registers
//
// Overview of operation
// - per serviced microframe a 12-bit received count is written back
// - counts 7,6 in high word of dw7; 4,3 in dw6 low word
// - count 5 split: low byte in dw7 high, top nibble dw6[31:28]
// - count 2 split: top nibble dw6[3:0], low byte dw5[63:56]
// - counts 1 and 0 in dw5 bits 55..44 and 43..32
// - one 3-bit result per microframe in dw4, uframe7 at 31..29
// - result written only after the microframe's transaction finished
// - result bit 0 flags a transaction error, in and out
// - result bit 1 flags babble, in transfers only
// - result bit 2 flags data underrun, out transfers only
// - schedule mask consulted only when frame select matches bus frame
// - microframe n serviced only if schedule mask bit n is one
// - software only sets mask bits; hardware clears them after processing
// - active flag always written equal to the valid flag
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/10ps
module hiu_uframe_desc (
	input  wire logic        clk,          // core clock, 10 MHz
	input  wire logic        reset_n,      // async reset, active low
	input  wire logic [3:0]  regAddr,      // register index
	input  wire logic [31:0] regWdata,     // write data
	input  wire logic        regWr,        // write strobe
	input  wire logic        regRd,        // read strobe
	output logic      [31:0] regRdata,     // read data, cycle after strobe
	input  wire logic [4:0]  busFrame,     // current bus frame number bits
	input  wire logic        uframeStart,  // pulse at each microframe start
	input  wire logic [2:0]  uframeIdx,    // microframe number of that start
	output logic             txnReq,       // transaction wanted, level
	output logic      [2:0]  txnUframe,    // microframe of the request
	output logic             txnOut,       // request is an out transfer
	input  wire logic        txnDone,      // transaction finished, pulse
	input  wire logic [11:0] txnCount,     // bytes moved, with txnDone
	input  wire logic        txnError,     // transaction error, with txnDone
	input  wire logic        txnBabble,    // babble seen, with txnDone
	input  wire logic        txnUnderrun,  // underrun seen, with txnDone
	output logic             irq           // level interrupt
);

	// ====================================================================
	// state
	// sequencer
	hiu_pkg::hiu_state_e state_q, state_d;
	logic [2:0]  curUframe_q, curUframe_d;
	logic        txnReq_q, txnReq_d;

	// descriptor fields, one count and one result per microframe
	logic [11:0] count_q  [hiu_pkg::NUM_UFRAMES];
	logic [11:0] count_d  [hiu_pkg::NUM_UFRAMES];
	logic [2:0]  result_q [hiu_pkg::NUM_UFRAMES];
	logic [2:0]  result_d [hiu_pkg::NUM_UFRAMES];
	logic [7:0]  schedMask_q, schedMask_d;
	logic [4:0]  frameSel_q, frameSel_d;
	logic        active_q, active_d;
	logic        valid_q, valid_d;
	logic        dirOut_q, dirOut_d;

	// sticky events and their mask
	logic [1:0]  evStat_q, evStat_d;
	logic [1:0]  evMask_q, evMask_d;

	// read path
	logic [31:0] rdata_q, rdata_d;

	// ====================================================================
	// read word assembly, shared by the read path
	function automatic logic [31:0] readWord(input logic [3:0] a);
		logic [31:0] w;
		w = hiu_pkg::RST_WORD;
		// unmapped indices fall through and read as zero
		if (a == hiu_pkg::ADDR_DW1_LO) begin
			// frame select only; the rest of this word is not kept here
			w[hiu_pkg::FRAME_SEL_LSB +: hiu_pkg::FRAME_W] = frameSel_q;
		end else if (a == hiu_pkg::ADDR_DW3_HI) begin
			// only the active flag lives in this word
			w[hiu_pkg::ACTIVE_BIT] = active_q;
		end else if (a == hiu_pkg::ADDR_DW4_LO) begin
			// results above the schedule mask, microframe 0 lowest
			for (int i = 0; i < hiu_pkg::NUM_UFRAMES; i++) begin
				w[8 + 3 * i +: 3] = result_q[i];
			end
			w[7:0] = schedMask_q;
		end else if (a == hiu_pkg::ADDR_DW5_HI) begin
			// low byte of count 2 on top, then counts 1 and 0
			w = {count_q[2][7:0], count_q[1], count_q[0]};
		end else if (a == hiu_pkg::ADDR_DW6_LO) begin
			// top nibbles of counts 5 and 2 frame counts 4 and 3
			w = {count_q[5][11:8], count_q[4], count_q[3], count_q[2][11:8]};
		end else if (a == hiu_pkg::ADDR_DW7_HI) begin
			// counts 7 and 6, then the low byte of count 5
			w = {count_q[7], count_q[6], count_q[5][7:0]};
		end else if (a == hiu_pkg::ADDR_CTRL) begin
			// valid and direction as software last wrote them
			w[hiu_pkg::CTRL_VALID_BIT] = valid_q;
			w[hiu_pkg::CTRL_OUT_BIT]   = dirOut_q;
		end else if (a == hiu_pkg::ADDR_IRQ_STAT) begin
			w[1:0] = evStat_q;
		end else if (a == hiu_pkg::ADDR_IRQ_MASK) begin
			w[1:0] = evMask_q;
		end
		return w;
	endfunction

	// ====================================================================
	// schedule decision at a microframe start
	logic frameMatch;
	logic startOk;

	// frame compare gates the mask; an inactive descriptor never issues
	assign frameMatch = (frameSel_q == busFrame);
	assign startOk    = uframeStart && active_q && frameMatch
		&& schedMask_q[uframeIdx];

	// ====================================================================
	// completion of the outstanding transaction
	logic       txnFinish;
	logic [2:0] finishResult;

	// outcome flags folded into one result; the direction masks the flag
	// that cannot occur for that token, so a noisy engine cannot set it
	function automatic logic [2:0] resultCode(input logic err, input logic babble,
		input logic underrun, input logic isOut);
		logic [2:0] r;
		r = hiu_pkg::RST_RESULT;
		r[hiu_pkg::RES_TXERR_BIT]    = err;
		r[hiu_pkg::RES_BABBLE_BIT]   = babble && !isOut;
		r[hiu_pkg::RES_UNDERRUN_BIT] = underrun && isOut;
		return r;
	endfunction

	// a done pulse counts only while a request is outstanding
	assign txnFinish    = (state_q == hiu_pkg::ST_BUSY) && txnDone;
	assign finishResult = resultCode(txnError, txnBabble, txnUnderrun, dirOut_q);

	// ====================================================================
	// transaction sequencer
	always_comb begin
		state_d     = state_q;
		curUframe_d = curUframe_q;
		txnReq_d    = txnReq_q;
		// a start while busy is dropped: one transaction per microframe at most
		case (state_q)
			hiu_pkg::ST_IDLE: begin
				// frame, mask and active are already folded into startOk
				if (startOk) begin
					state_d     = hiu_pkg::ST_BUSY;
					curUframe_d = uframeIdx;
					txnReq_d    = 1'b1;
				end
			end
			hiu_pkg::ST_BUSY: begin
				// request stands until the engine reports the outcome
				if (txnDone) begin
					state_d  = hiu_pkg::ST_IDLE;
					txnReq_d = 1'b0;
				end
			end
			default: begin
				// stray encodings fall back to idle with no request
				state_d  = hiu_pkg::ST_IDLE;
				txnReq_d = 1'b0;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= hiu_pkg::ST_IDLE;
			curUframe_q <= 3'h0;
			txnReq_q    <= 1'b0;
		end else begin
			state_q     <= state_d;
			curUframe_q <= curUframe_d;
			txnReq_q    <= txnReq_d;
		end
	end

	// ====================================================================
	// descriptor fields: hardware write-back and software set-up
	always_comb begin
		count_d     = count_q;
		result_d    = result_q;
		schedMask_d = schedMask_q;
		frameSel_d  = frameSel_q;
		active_d    = active_q;
		valid_d     = valid_q;
		dirOut_d    = dirOut_q;
		// only the serviced microframe is touched, the others keep their fields
		if (txnFinish) begin
			result_d[curUframe_q]    = finishResult;
			count_d[curUframe_q]     = txnCount;
			schedMask_d[curUframe_q] = 1'b0;
			active_d                 = valid_q;
		end
		// software writes; a mask write can only raise bits, so it also wins
		// over a same-cycle hardware clear of a freshly rescheduled bit
		if (regWr) begin
			if (regAddr == hiu_pkg::ADDR_DW1_LO) begin
				// frame select compared against the bus frame bits
				frameSel_d = regWdata[hiu_pkg::FRAME_SEL_LSB +: hiu_pkg::FRAME_W];
			end else if (regAddr == hiu_pkg::ADDR_DW3_HI) begin
				// a write here only copies valid; its data is ignored
				active_d = valid_q;
			end else if (regAddr == hiu_pkg::ADDR_DW4_LO) begin
				// or-in: software can schedule but never unschedule
				schedMask_d = schedMask_d | regWdata[7:0];
			end else if (regAddr == hiu_pkg::ADDR_CTRL) begin
				// valid and active move together so the pair never disagrees
				valid_d  = regWdata[hiu_pkg::CTRL_VALID_BIT];
				dirOut_d = regWdata[hiu_pkg::CTRL_OUT_BIT];
				active_d = regWdata[hiu_pkg::CTRL_VALID_BIT];
			end
		end
	end

	// descriptor registers; counts and results clear on reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < hiu_pkg::NUM_UFRAMES; i++) begin
				count_q[i]  <= hiu_pkg::RST_COUNT;
				result_q[i] <= hiu_pkg::RST_RESULT;
			end
			schedMask_q <= 8'h00;
			frameSel_q  <= 5'h00;
			active_q    <= 1'b0;
			valid_q     <= 1'b0;
			dirOut_q    <= 1'b0;
		end else begin
			count_q     <= count_d;
			result_q    <= result_d;
			schedMask_q <= schedMask_d;
			frameSel_q  <= frameSel_d;
			active_q    <= active_d;
			valid_q     <= valid_d;
			dirOut_q    <= dirOut_d;
		end
	end

	// ====================================================================
	// sticky events and their mask
	always_comb begin
		logic [1:0] ev;
		ev       = 2'h0;
		evMask_d = evMask_q;
		evStat_d = evStat_q;
		// done on every completion, error when any result bit is set
		ev[hiu_pkg::EV_DONE_BIT] = txnFinish;
		ev[hiu_pkg::EV_ERR_BIT]  = txnFinish && (finishResult != hiu_pkg::RST_RESULT);
		if (regWr && regAddr == hiu_pkg::ADDR_IRQ_MASK) begin
			evMask_d = regWdata[1:0];
		end
		// write one clears; an event in the same cycle wins so none is lost
		if (regWr && regAddr == hiu_pkg::ADDR_IRQ_STAT) begin
			evStat_d = evStat_q & ~regWdata[1:0];
		end
		evStat_d = evStat_d | ev;
	end

	// event registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			evStat_q <= 2'h0;
			evMask_q <= 2'h0;
		end else begin
			evStat_q <= evStat_d;
			evMask_q <= evMask_d;
		end
	end

	// ====================================================================
	// read data: zero except in the cycle after a read strobe
	always_comb begin
		rdata_d = hiu_pkg::RST_WORD;
		if (regRd) begin
			rdata_d = readWord(regAddr);
		end
	end

	// read data register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= hiu_pkg::RST_WORD;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ====================================================================
	// outputs
	// all but irq come straight from flip-flops; irq is the AND of the
	// registered status and mask, a level while any unmasked event stands
	assign regRdata  = rdata_q;
	assign txnReq    = txnReq_q;
	assign txnUframe = curUframe_q;
	assign txnOut    = dirOut_q;
	assign irq       = |(evStat_q & evMask_q);

endmodule

// >>> tb/hiu_txn_model.sv
// transaction engine model: answers each request after a set delay
`timescale 1ns/10ps
module hiu_txn_model (
	input  wire logic        clk,      // core clock
	input  wire logic        txnReq,   // request from the block
	input  wire logic [3:0]  dly,      // answer delay in cycles
	input  wire logic [14:0] res,      // {count, error, babble, underrun}
	output logic             txnDone,  // completion pulse
	output logic      [11:0] txnCount, // bytes, garbage off the pulse
	output logic      [2:0]  txnFlags  // outcome flags with the pulse
);
	logic [3:0] waitCnt_q = 4'h0;
	// countdown reloads while idle, so a zero delay answers at once
	always @(posedge clk) begin
		if (!txnReq || txnDone) begin
			waitCnt_q <= dly;
		end else if (waitCnt_q != 4'h0) begin
			waitCnt_q <= waitCnt_q - 4'h1;
		end
	end
	// no pull on these lines: inverted values outside the pulse
	assign txnDone = txnReq && waitCnt_q == 4'h0;
	assign txnCount = txnDone ? res[14:3] : ~res[14:3];
	assign txnFlags = txnDone ? res[2:0] : ~res[2:0];
endmodule

// >>> tb/hiu_uframe_desc_sva.sv
// port checker for the interrupt microframe descriptor block
`timescale 1ns/10ps
module hiu_uframe_desc_sva (
	input wire logic        clk,         // core clock
	input wire logic        reset_n,     // async reset, active low
	input wire logic        regRd,       // read strobe
	input wire logic [31:0] regRdata,    // read data
	input wire logic        uframeStart, // microframe start pulse
	input wire logic [2:0]  uframeIdx,   // microframe number
	input wire logic        txnReq,      // request level
	input wire logic [2:0]  txnUframe,   // requested microframe
	input wire logic        txnOut,      // direction
	input wire logic        txnDone      // completion pulse
);
	// ==========
	// request handshake and idle read data
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_req_from_start: assert property ($rose(txnReq) |-> $past(uframeStart))
		else $error("request without start");
	a_req_idx: assert property ($rose(txnReq) |-> txnUframe == $past(uframeIdx))
		else $error("wrong microframe");
	a_quiet_idle: assert property (!txnReq && !uframeStart |=> !txnReq)
		else $error("request from nowhere");
	a_req_holds: assert property (txnReq && !txnDone |=> txnReq)
		else $error("request dropped early");
	a_uframe_stable: assert property (txnReq && !txnDone |=> $stable(txnUframe))
		else $error("microframe moved");
	a_dir_stable: assert property (txnReq && !txnDone |=> $stable(txnOut))
		else $error("direction moved");
	a_done_drop: assert property (txnReq && txnDone |=> !txnReq)
		else $error("request kept");
	a_rdata_zero: assert property (!$past(regRd) |-> regRdata == 32'h0)
		else $error("read data stale");
endmodule

bind hiu_uframe_desc hiu_uframe_desc_sva u_hiu_uframe_desc_sva (.clk, .reset_n, .regRd,
	.regRdata, .uframeStart, .uframeIdx, .txnReq, .txnUframe, .txnOut, .txnDone);

// >>> tb/hiu_uframe_desc_test.sv
// self-checking bench for the interrupt microframe descriptor block
`timescale 1ns/10ps
module hiu_uframe_desc_test;
	logic        clk, reset_n, regWr, regRd, uframeStart, txnReq, txnOut, txnDone, irq, outExp;
	logic [3:0]  regAddr, dly;
	logic [31:0] regWdata, regRdata;
	logic [4:0]  busFrame;
	logic [2:0]  uframeIdx, txnUframe, fl;
	logic [11:0] txnCount;
	logic [14:0] res;
	logic [11:0] c [8];
	logic [2:0]  r [8];
	logic [31:0] d;
	int          n_errors, checks, cyc = 0;
	hiu_uframe_desc u_hiu_uframe_desc (.clk, .reset_n, .regAddr, .regWdata, .regWr, .regRd,
		.regRdata, .busFrame, .uframeStart, .uframeIdx, .txnReq, .txnUframe, .txnOut, .txnDone,
		.txnCount, .txnError(fl[2]), .txnBabble(fl[1]), .txnUnderrun(fl[0]), .irq);
	hiu_txn_model u_hiu_txn_model (.clk, .txnReq, .dly, .res, .txnDone, .txnCount, .txnFlags(fl));
	// ==========
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			final_report;
		end
	end
	// ==========
	// bus and compare tasks; a gap cycle between strobes avoids double drives
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 chk(regRdata, e);
	endtask
	// one microframe start, then wait out the transaction if one is expected
	task automatic serve(input logic [2:0] u, input logic [14:0] rs, input logic [3:0] dl,
		input logic e);
		int k;
		@(posedge clk);
		uframeIdx <= u;
		uframeStart <= 1'b1;
		res <= rs;
		dly <= dl;
		@(posedge clk);
		uframeStart <= 1'b0;
		#1 chk(txnReq, e);
		if (e) chk(txnUframe, u);
		if (e) chk(txnOut, outExp);
		for (k = 0; k < 20 && txnReq === 1'b1; k++) @(posedge clk) #1;
		chk(txnReq, 1'b0);
	endtask
	task automatic words;
		rd(hiu_pkg::ADDR_DW5_HI, {c[2][7:0], c[1], c[0]});
		rd(hiu_pkg::ADDR_DW6_LO, {c[5][11:8], c[4], c[3], c[2][11:8]});
		rd(hiu_pkg::ADDR_DW7_HI, {c[7], c[6], c[5][7:0]});
		rd(hiu_pkg::ADDR_DW4_LO, {r[7], r[6], r[5], r[4], r[3], r[2], r[1], r[0], 8'h00});
	endtask
	// ==========
	// scenarios
	task automatic s_gate;
		for (int a = 0; a < 16; a++) rd(4'(a), 32'h0);
		wr(hiu_pkg::ADDR_DW1_LO, 32'h28);
		wr(hiu_pkg::ADDR_CTRL, 32'h1);
		rd(hiu_pkg::ADDR_DW3_HI, 32'h8000_0000);
		wr(hiu_pkg::ADDR_CTRL, 32'h0);
		rd(hiu_pkg::ADDR_DW3_HI, 32'h0);
		wr(hiu_pkg::ADDR_DW4_LO, 32'h08);
		serve(3'h3, 15'h0, 4'h0, 1'b0);
		wr(hiu_pkg::ADDR_CTRL, 32'h1);
		@(posedge clk);
		busFrame <= 5'h04;
		serve(3'h3, 15'h0, 4'h0, 1'b0);
		@(posedge clk);
		busFrame <= 5'h05;
		serve(3'h2, 15'h0, 4'h0, 1'b0);
		serve(3'h3, {12'h0AB, 3'h0}, 4'h1, 1'b1);
		rd(hiu_pkg::ADDR_DW6_LO, 32'h0000_0AB0);
		rd(hiu_pkg::ADDR_DW4_LO, 32'h0);
		serve(3'h3, 15'h0, 4'h0, 1'b0);
	endtask
	task automatic s_all;
		wr(hiu_pkg::ADDR_DW4_LO, 32'hFF);
		for (int u = 0; u < 8; u++) begin
			c[u] = 12'(12'h357 * (u + 1));
			r[u] = {2'b01, u[0]};
			serve(3'(u), {c[u], u[0], 2'b11}, 4'(u), 1'b1);
		end
		words;
		wr(hiu_pkg::ADDR_CTRL, 32'h3);
		outExp = 1'b1;
		wr(hiu_pkg::ADDR_DW4_LO, 32'h01);
		c[0] = 12'h001;
		r[0] = 3'h5;
		serve(3'h0, 15'h000F, 4'h3, 1'b1);
		wr(hiu_pkg::ADDR_DW7_HI, 32'hFFFF_FFFF);
		words;
	endtask
	task automatic s_irq;
		rd(hiu_pkg::ADDR_IRQ_STAT, 32'h3);
		chk(irq, 1'b0);
		wr(hiu_pkg::ADDR_IRQ_MASK, 32'h1);
		chk(irq, 1'b1);
		wr(hiu_pkg::ADDR_IRQ_STAT, 32'h1);
		chk(irq, 1'b0);
		wr(hiu_pkg::ADDR_IRQ_MASK, 32'h2);
		chk(irq, 1'b1);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ==========
	// main sequence
	initial begin
		{reset_n, regWr, regRd, uframeStart, regAddr, regWdata, uframeIdx, dly, res, outExp} = '0;
		busFrame = 5'h05;
		n_errors = 0;
		checks = 0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		s_gate;
		s_all;
		s_irq;
		final_report;
	end
endmodule
